// ---- hdl/skey_activity.v ----
// Storage key array with activity recording, APB registers and pretest.
`timescale 1ns/1ps
`include "skey_map.vh"
module skey_activity (
   input wire clk_sys_i,
   input wire rst_n_i,
   // APB slave.
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // Storage access observation, processor, channel and console paths.
   input wire cpu_rd_i,
   input wire cpu_wr_i,
   input wire [`ADDR_W-1:0] cpu_addr_i,
   input wire chan_rd_i,
   input wire chan_wr_i,
   input wire [`ADDR_W-1:0] chan_addr_i,
   input wire con_rd_i,
   input wire con_wr_i,
   input wire [`ADDR_W-1:0] con_addr_i,
   // Translation result for the probe fetch and for execution.
   input wire probe_done_i,
   input wire pte_invalid_i,
   input wire exec_fault_i,
   output wire probe_req_o,
   output wire [`ADDR_W-1:0] probe_addr_o,
   output wire exec_go_o,
   output wire commit_o,
   output wire nullify_o,
   output wire supervisor_o
);

   // ****************************************************************
   // Key storage.
   // ****************************************************************
   // seven-bit key per block
   reg [`KEY_W-1:0] key_mem [0:`NBLK-1];
   reg [`BLK_W-1:0] block_reg;
   reg [`KEY_W-1:0] key_wdata_reg;
   reg [`KEY_W-1:0] key_rdata_reg;
   reg [`ADDR_W-1:0] op_addr_reg;
   reg [2:0] nstat_reg;
   reg [31:0] prdata_reg;
   integer i;

   // Block index of a real address; used for every access path.
   function [`BLK_W-1:0] blk_of;
      input [`ADDR_W-1:0] a;
      begin
         blk_of = a[`ADDR_W-1:`BLK_SHIFT];
      end
   endfunction

   wire apb_wr;
   wire apb_rd;
   wire mapped;
   wire do_clr_ref;
   wire do_set_key;
   wire do_inspect;

   // Single-cycle access phase; pready always high.
   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign apb_rd = psel_i && penable_i && !pwrite_i;
   assign mapped = (paddr_i <= `REG_PROBE_ADDR) && (paddr_i[1:0] == 2'b00);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign prdata_o = prdata_reg;
   assign do_clr_ref = apb_wr && (paddr_i == `REG_CTRL) && pwdata_i[`CMD_CLR_REF];
   assign do_set_key = apb_wr && (paddr_i == `REG_CTRL) && pwdata_i[`CMD_SET_KEY];
   assign do_inspect = apb_wr && (paddr_i == `REG_CTRL) && pwdata_i[`CMD_INSPECT];

   // ****************************************************************
   // Activity recording.
   // ****************************************************************
   // Three access paths could hit three blocks at once, so each path gets
   // its own write port; a merge per block keeps all flag settings.
   wire [2:0] acc_rd;
   wire [2:0] acc_wr;
   wire [`BLK_W-1:0] acc_blk [0:2];
   assign acc_rd = {con_rd_i, chan_rd_i, cpu_rd_i};
   assign acc_wr = {con_wr_i, chan_wr_i, cpu_wr_i};
   assign acc_blk[0] = blk_of(cpu_addr_i);
   assign acc_blk[1] = blk_of(chan_addr_i);
   assign acc_blk[2] = blk_of(con_addr_i);

   // Merged set masks per path, OR-ing all paths that hit the same block.
   wire [1:0] set_mask [0:2];
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_merge
         wire [2:0] same;
         assign same[0] = (acc_blk[0] == acc_blk[g]) && (acc_rd[0] || acc_wr[0]);
         assign same[1] = (acc_blk[1] == acc_blk[g]) && (acc_rd[1] || acc_wr[1]);
         assign same[2] = (acc_blk[2] == acc_blk[g]) && (acc_rd[2] || acc_wr[2]);
         assign set_mask[g][1] = |same;
         assign set_mask[g][0] = |(same & acc_wr);
      end
   endgenerate

   // Key array update. Hardware sets win over a same-cycle software clear.
   // The array has no reset, so software must load every key it relies on.
   always @(posedge clk_sys_i) begin
      if (do_set_key) begin
         key_mem[block_reg] <= key_wdata_reg;
      end else if (do_clr_ref) begin
         key_mem[block_reg] <= key_mem[block_reg] & ~(7'h01 << `KEY_REF_BIT);
      end
      for (i = 0; i < 3; i = i + 1) begin
         if (acc_rd[i] || acc_wr[i]) begin
            if (do_set_key && acc_blk[i] == block_reg) begin
               key_mem[acc_blk[i]] <= key_wdata_reg
                  | {{(`KEY_W-2){1'b0}}, set_mask[i]};
            end else begin
               key_mem[acc_blk[i]] <= key_mem[acc_blk[i]]
                  | {{(`KEY_W-2){1'b0}}, set_mask[i]};
            end
         end
      end
   end

   // ****************************************************************
   // APB registers.
   // ****************************************************************
   // Register writes, and read data loaded in the setup cycle.
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         block_reg <= {`BLK_W{1'b0}};
         key_wdata_reg <= `KEY_RESET;
         key_rdata_reg <= `KEY_RESET;
         op_addr_reg <= {`ADDR_W{1'b0}};
         prdata_reg <= 32'h0000_0000;
      end else begin
         if (apb_wr && paddr_i == `REG_BLOCK) begin
            block_reg <= pwdata_i[`BLK_W-1:0];
         end
         if (apb_wr && paddr_i == `REG_KEY_WDATA) begin
            key_wdata_reg <= pwdata_i[`KEY_W-1:0];
         end
         if (apb_wr && paddr_i == `REG_PROBE_ADDR) begin
            op_addr_reg <= pwdata_i[`ADDR_W-1:0];
         end
         if (do_inspect) begin
            key_rdata_reg <= key_mem[block_reg];
         end
         prdata_reg <= 32'h0000_0000;
         if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
               `REG_BLOCK: prdata_reg <= {19'h0_0000, block_reg};
               `REG_KEY_WDATA: prdata_reg <= {25'h000_0000, key_wdata_reg};
               `REG_KEY_RDATA: prdata_reg <= {25'h000_0000, key_rdata_reg};
               `REG_NULL_STAT: prdata_reg <= {29'h0000_0000, nstat_reg};
               `REG_PROBE_ADDR: prdata_reg <= {8'h00, op_addr_reg};
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************************************
   // Nullification pretest.
   // ****************************************************************
   wire nc_wr;
   wire busy;
   wire probe_fault;
   assign nc_wr = apb_wr && (paddr_i == `REG_NULL_CTRL);
   assign probe_fault = pte_invalid_i;

   // Status: busy, last nullified, last committed. Hardware set wins.
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         nstat_reg <= 3'b000;
      end else begin
         nstat_reg[`NS_BUSY] <= busy;
         if (nullify_o) begin
            nstat_reg[`NS_NULLED] <= 1'b1;
         end else if (apb_wr && paddr_i == `REG_NULL_STAT && pwdata_i[`NS_NULLED]) begin
            nstat_reg[`NS_NULLED] <= 1'b0;
         end
         if (commit_o) begin
            nstat_reg[`NS_COMMITTED] <= 1'b1;
         end else if (apb_wr && paddr_i == `REG_NULL_STAT && pwdata_i[`NS_COMMITTED]) begin
            nstat_reg[`NS_COMMITTED] <= 1'b0;
         end
      end
   end

   // Control word: bit 0 start, bit 1 unit done, bit 2 abort,
   // bit 3 references storage, bit 4 word store operand.
   skey_pretest u_pretest (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .start_i(nc_wr && pwdata_i[`NC_START]),
      .refs_storage_i(pwdata_i[`NC_REFS]),
      .word_op_i(pwdata_i[`NC_WORD]),
      .op_addr_i(op_addr_reg),
      .probe_done_i(probe_done_i),
      .probe_fault_i(probe_fault),
      .exec_fault_i(exec_fault_i),
      .unit_done_i(nc_wr && pwdata_i[`NC_UNIT_DONE]),
      .abort_i(nc_wr && pwdata_i[`NC_ABORT]),
      .probe_req_o(probe_req_o),
      .probe_addr_o(probe_addr_o),
      .exec_go_o(exec_go_o),
      .commit_o(commit_o),
      .nullify_o(nullify_o),
      .supervisor_o(supervisor_o),
      .busy_o(busy)
   );

endmodule // skey_activity

// ---- hdl/skey_map.vh ----
// Constants for the storage key activity and nullify block.
//
// How it works
// - Seven-bit key per 2K block.
// - Any read sets the referenced flag.
// - Any write sets modified and referenced.
// - Recording is always on, mode-independent.
// - Console accesses record like processor accesses.
// - Clear-referenced touches only referenced flag.
// - Modified flag cleared only by write-key.
// - Nullify: no change, status points back.
// - Fault nullifies only current execution unit.
// - Pretest only real-storage-referencing instructions.
// - Pretest runs before normal execution.
// - Aligned operand skips the pretest.
// - Misaligned word store probes address plus three.
// - Clean probe lets instruction proceed.
// - Faulting probe nullifies, hands to supervisor.
// - First-page fault during execution also nullifies.
// - Invalid page entry raises translation exception.
`ifndef SKEY_MAP_VH
`define SKEY_MAP_VH

// ****************************************************************
// Register map, byte offsets on the APB.
// ****************************************************************
`define REG_CTRL 12'h000
`define REG_BLOCK 12'h004
`define REG_KEY_WDATA 12'h008
`define REG_KEY_RDATA 12'h00C
`define REG_NULL_CTRL 12'h010
`define REG_NULL_STAT 12'h014
`define REG_PROBE_ADDR 12'h018

// ****************************************************************
// Key field layout and geometry.
// ****************************************************************
`define KEY_W 7
`define KEY_PROT_LSB 3
`define KEY_FGUARD_BIT 2
`define KEY_REF_BIT 1
`define KEY_MOD_BIT 0
`define ADDR_W 24
`define BLK_SHIFT 11
`define BLK_W 13
`define NBLK 8192
`define KEY_RESET 7'h00

// Control register bits.
`define CMD_CLR_REF 0
`define CMD_SET_KEY 1
`define CMD_INSPECT 2

// Nullify control bits.
`define NC_START 0
`define NC_UNIT_DONE 1
`define NC_ABORT 2
`define NC_REFS 3
`define NC_WORD 4

// Nullify status bits; the two sticky ones clear on a written one.
`define NS_BUSY 0
`define NS_NULLED 1
`define NS_COMMITTED 2

// Probe offset to the highest byte of a word operand.
`define PROBE_OFS 24'h00_0003

`endif

// ---- hdl/skey_pretest.v ----
// Nullification pretest sequencer for one instruction or execution unit.
`timescale 1ns/1ps
`include "skey_map.vh"
module skey_pretest (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire start_i,
   input wire refs_storage_i,
   input wire word_op_i,
   input wire [`ADDR_W-1:0] op_addr_i,
   input wire probe_done_i,
   input wire probe_fault_i,
   input wire exec_fault_i,
   input wire unit_done_i,
   input wire abort_i,
   output reg probe_req_o,
   output reg [`ADDR_W-1:0] probe_addr_o,
   output reg exec_go_o,
   output reg commit_o,
   output reg nullify_o,
   output reg supervisor_o,
   output reg busy_o
);

   // ****************************************************************
   // State machine.
   // ****************************************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_PROBE = 2'd1;
   localparam ST_EXEC = 2'd2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   wire aligned;

   // Word operand is aligned when its two low bits are zero.
   assign aligned = (op_addr_i[1:0] == 2'b00);

   // Outputs other than busy_o are registered; each event output is a one-cycle pulse.
   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         probe_req_o <= 1'b0;
         probe_addr_o <= {`ADDR_W{1'b0}};
         exec_go_o <= 1'b0;
         commit_o <= 1'b0;
         nullify_o <= 1'b0;
         supervisor_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         probe_req_o <= 1'b0;
         exec_go_o <= 1'b0;
         commit_o <= 1'b0;
         nullify_o <= 1'b0;
         supervisor_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (start_i) begin
                  if (!refs_storage_i || !word_op_i || aligned) begin
                     exec_go_o <= 1'b1;
                  end else begin
                     probe_req_o <= 1'b1;
                     probe_addr_o <= op_addr_i + `PROBE_OFS;
                  end
               end
            end
            ST_PROBE: begin
               if (probe_done_i) begin
                  if (probe_fault_i) begin
                     nullify_o <= 1'b1;
                     supervisor_o <= 1'b1;
                  end else begin
                     exec_go_o <= 1'b1;
                  end
               end
            end
            ST_EXEC: begin
               if (exec_fault_i) begin
                  nullify_o <= 1'b1;
                  supervisor_o <= 1'b1;
               end else if (unit_done_i) begin
                  commit_o <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Next state; abort returns to idle from anywhere.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_i) begin
               if (!refs_storage_i || !word_op_i || aligned) begin
                  state_next = ST_EXEC;
               end else begin
                  state_next = ST_PROBE;
               end
            end
         end
         ST_PROBE: begin
            if (probe_done_i) begin
               state_next = probe_fault_i ? ST_IDLE : ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (exec_fault_i || unit_done_i) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (abort_i) begin
         state_next = ST_IDLE;
      end
   end

   // Busy while a sequence is open.
   always @* begin
      busy_o = (state_reg != ST_IDLE);
   end

endmodule // skey_pretest

// ---- dv/skey_activity_checker.sv ----
// Concurrent checks on the pretest outputs of the storage key block.
`timescale 1ns/1ps
`include "skey_map.vh"
module skey_activity_checker (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire probe_done_i,
   input wire pte_invalid_i,
   input wire exec_fault_i,
   input wire probe_req_o,
   input wire [`ADDR_W-1:0] probe_addr_o,
   input wire exec_go_o,
   input wire commit_o,
   input wire nullify_o,
   input wire supervisor_o
);
   // ****************************************
   // Helper state and sequences.
   // ****************************************
   reg [`ADDR_W-1:0] op_reg;
   wire wr_take = psel_i && penable_i && pwrite_i;
   // Shadow the operand address so that the probe target can be predicted.
   always @(posedge clk_sys_i) begin
      if (wr_take && paddr_i == `REG_PROBE_ADDR) begin
         op_reg <= pwdata_i[`ADDR_W-1:0];
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_start;
      wr_take && paddr_i == `REG_NULL_CTRL && pwdata_i[`NC_START];
   endsequence
   sequence s_pretest;
      s_start ##0 (pwdata_i[`NC_REFS] && pwdata_i[`NC_WORD] && op_reg[1:0] != 2'b00);
   endsequence
   sequence s_no_pretest;
      s_start ##0 (!pwdata_i[`NC_REFS] || !pwdata_i[`NC_WORD] || op_reg[1:0] == 2'b00);
   endsequence
   // ****************************************
   // Assertions.
   // ****************************************
   a_skip_pretest: assert property (
      s_no_pretest |=> exec_go_o && !probe_req_o)
      else $error("start without pretest did not execute at once");
   a_probe_first: assert property (
      s_pretest |=> probe_req_o && !exec_go_o)
      else $error("misaligned word store did not probe first");
   a_probe_plus3: assert property (
      probe_req_o |-> probe_addr_o == op_reg + `PROBE_OFS)
      else $error("probe address is not operand plus three");
   a_clean_probe: assert property (
      probe_done_i && !pte_invalid_i |=> exec_go_o && !nullify_o)
      else $error("clean probe did not start execution");
   a_fault_probe: assert property (
      probe_done_i && pte_invalid_i |=> nullify_o && supervisor_o)
      else $error("faulting probe did not nullify");
   a_exec_fault: assert property (
      exec_fault_i |=> nullify_o && supervisor_o)
      else $error("execution fault did not nullify");
   a_null_quiet: assert property (
      nullify_o |-> !commit_o && !exec_go_o)
      else $error("nullify came with a commit or execution");
   a_unit_commit: assert property (
      wr_take && paddr_i == `REG_NULL_CTRL && pwdata_i[`NC_UNIT_DONE] |=> commit_o && !nullify_o)
      else $error("finished unit was not committed");
endmodule // skey_activity_checker

// ---- dv/skey_probe_model.sv ----
// Behavioural translation responder answering the block's probe fetches.
`timescale 1ns/1ps
module skey_probe_model (
   input wire clk_sys_i,
   input wire probe_req_i,
   input wire fault_i,
   input wire [3:0] dly_i,
   output reg probe_done_o,
   output wire pte_invalid_o
);
   reg [3:0] cnt = 4'h0;
   reg toggle = 1'b0;
   initial probe_done_o = 1'b0;
   // Count down the translation time, then report once; a zero delay is not allowed.
   always @(posedge clk_sys_i) begin
      probe_done_o <= 1'b0;
      toggle <= ~toggle;
      if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
         probe_done_o <= (cnt == 4'h1);
      end else if (probe_req_i) begin
         cnt <= dly_i;
      end
   end
   // invalid entry faults
   // The fault flag means nothing outside the done pulse, so it wobbles there.
   assign pte_invalid_o = probe_done_o ? fault_i : toggle;
endmodule // skey_probe_model

// ---- dv/skey_activity_tb.sv ----
// Self-checking bench for the storage key activity and nullify block.
`timescale 1ns/1ps
`include "skey_map.vh"
module skey_activity_tb;
   reg clk_sys_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0;
   reg [5:0] acc = 6'h00;
   reg [`ADDR_W-1:0] acc_addr = 24'h00_0000;
   reg exec_fault = 1'b0;
   reg fault = 1'b0;
   reg [3:0] dly = 4'h1;
   reg [`ADDR_W-1:0] last_probe;
   reg [31:0] rd;
   reg err;
   wire [31:0] prdata;
   wire [`ADDR_W-1:0] probe_addr;
   wire pready, pslverr, probe_done, pte_invalid, probe_req;
   wire exec_go, commit, nullify, supervisor;
   integer n_mismatch = 0;
   integer num_checks = 0;
   integer n_probe = 0;
   integer i;
   skey_activity skey_activity_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cpu_rd_i(acc[5]),
      .cpu_wr_i(acc[4]), .cpu_addr_i(acc_addr), .chan_rd_i(acc[3]), .chan_wr_i(acc[2]),
      .chan_addr_i(acc_addr), .con_rd_i(acc[1]), .con_wr_i(acc[0]), .con_addr_i(acc_addr),
      .probe_done_i(probe_done), .pte_invalid_i(pte_invalid), .exec_fault_i(exec_fault),
      .probe_req_o(probe_req), .probe_addr_o(probe_addr), .exec_go_o(exec_go),
      .commit_o(commit), .nullify_o(nullify), .supervisor_o(supervisor));
   skey_probe_model skey_probe_model_i (.clk_sys_i(clk_sys_i), .probe_req_i(probe_req),
      .fault_i(fault), .dly_i(dly), .probe_done_o(probe_done), .pte_invalid_o(pte_invalid));
   // ****************************************
   // Clock, probe monitor and tasks.
   // ****************************************
   always #2 clk_sys_i = ~clk_sys_i;
   // Count probes so a skipped or extra pretest shows up.
   always @(posedge clk_sys_i) begin
      if (probe_req === 1'b1) begin
         n_probe <= n_probe + 1;
         last_probe <= probe_addr;
      end
   end
   task check(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clk_sys_i);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk_sys_i);
         penable <= 1'b1;
         @(posedge clk_sys_i);
         while (pready !== 1'b1) @(posedge clk_sys_i);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task key_set(input [12:0] b, input [6:0] k);
      begin
         apb(1'b1, `REG_BLOCK, {19'h0, b});
         apb(1'b1, `REG_KEY_WDATA, {25'h0, k});
         apb(1'b1, `REG_CTRL, 32'h0000_0002);
      end
   endtask
   task key_chk(input [12:0] b, input [6:0] k);
      begin
         apb(1'b1, `REG_BLOCK, {19'h0, b});
         apb(1'b1, `REG_CTRL, 32'h0000_0004);
         apb(1'b0, `REG_KEY_RDATA, 32'h0);
         check(rd, {25'h0, k});
      end
   endtask
   task touch(input [5:0] w, input [`ADDR_W-1:0] a);
      begin
         @(posedge clk_sys_i);
         acc <= w;
         acc_addr <= a;
         @(posedge clk_sys_i);
         acc <= 6'h00;
      end
   endtask
   // One pretest pass; exp is committed and nullified, ctl is word op and refs storage.
   task run(input [`ADDR_W-1:0] a, input [1:0] ctl, input f, input ef, input [1:0] exp);
      integer k;
      integer np;
      begin
         fault <= f;
         np = n_probe;
         apb(1'b1, `REG_NULL_STAT, 32'h0000_0006);
         apb(1'b1, `REG_PROBE_ADDR, {8'h00, a});
         apb(1'b1, `REG_NULL_CTRL, {27'h0, ctl, 3'b001});
         k = 0;
         while (exec_go !== 1'b1 && nullify !== 1'b1 && k < 40) begin
            @(posedge clk_sys_i);
            k = k + 1;
         end
         if (exec_go === 1'b1 && ef) begin
            exec_fault <= 1'b1;
            @(posedge clk_sys_i);
            exec_fault <= 1'b0;
         end else if (exec_go === 1'b1) begin
            apb(1'b1, `REG_NULL_CTRL, 32'h0000_0002);
         end
         repeat (3) @(posedge clk_sys_i);
         apb(1'b0, `REG_NULL_STAT, 32'h0);
         check(rd[2:0], {exp, 1'b0});
         check(n_probe - np, (ctl == 2'b11 && a[1:0] != 2'b00));
         if (n_probe != np) check(last_probe, a + `PROBE_OFS);
      end
   endtask
   task complete_run;
      begin
         if (n_mismatch == 0 && num_checks > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   // ****************************************
   // Test sequence.
   // ****************************************
   initial begin
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      // Each access path hits the last byte of its block; the next block stays clean.
      for (i = 0; i < 6; i = i + 1) begin
         key_set(i[12:0], 7'h00);
         key_set(i[12:0] + 13'h1, 7'h00);
         touch(6'h20 >> i, {i[12:0], 11'h7FF});
         key_chk(i[12:0], i[0] ? 7'h03 : 7'h02);
         key_chk(i[12:0] + 13'h1, 7'h00);
      end
      key_set(13'h1FFF, 7'h7C);
      key_chk(13'h1FFF, 7'h7C);
      touch(6'h24, 24'hFF_F800);
      key_chk(13'h1FFF, 7'h7F);
      key_chk(13'h1FFF, 7'h7F);
      apb(1'b1, `REG_CTRL, 32'h0000_0001);
      key_chk(13'h1FFF, 7'h7D);
      key_set(13'h1FFF, 7'h50);
      key_chk(13'h1FFF, 7'h50);
      // An unmapped offset is refused and reads as zero.
      apb(1'b0, 12'h01C, 32'h0);
      check({31'h0, err}, 32'h0000_0001);
      check(rd, 32'h0);
      run(24'h00_1001, 2'b11, 1'b0, 1'b0, 2'b10);
      dly <= 4'h5;
      run(24'h00_2002, 2'b11, 1'b1, 1'b0, 2'b01);
      run(24'h00_37FF, 2'b11, 1'b0, 1'b1, 2'b01);
      run(24'h00_4000, 2'b11, 1'b0, 1'b0, 2'b10);
      run(24'h00_5003, 2'b01, 1'b0, 1'b0, 2'b10);
      run(24'h00_6003, 2'b10, 1'b0, 1'b0, 2'b10);
      // An abort abandons the open unit with neither a commit nor a nullify.
      apb(1'b1, `REG_NULL_STAT, 32'h0000_0006);
      apb(1'b1, `REG_NULL_CTRL, 32'h0000_0009);
      apb(1'b0, `REG_NULL_STAT, 32'h0);
      check(rd, 32'h0000_0001);
      apb(1'b1, `REG_NULL_CTRL, 32'h0000_0004);
      apb(1'b0, `REG_NULL_STAT, 32'h0);
      check(rd, 32'h0000_0000);
      complete_run;
   end
   // A hang is cut off well past the expected run length.
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      complete_run;
   end
endmodule // skey_activity_tb
bind skey_activity skey_activity_checker skey_activity_checker_i (.clk_sys_i, .rst_n_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .probe_done_i, .pte_invalid_i,
   .exec_fault_i, .probe_req_o, .probe_addr_o, .exec_go_o, .commit_o, .nullify_o,
   .supervisor_o);
